/* dv/sar_host_model.sv */
// Host serial controller model for the converter read port
`timescale 1ns/1ns

module sar_host_model #(
  parameter int SETUP_NS = 600,
  parameter int HALF_NS = 15
) (
  // Serial port pins
  output logic sel_n_o,
  output logic sclk_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i,
  // Received frame
  output logic [15:0] rx_word_o,
  output logic rx_ok_o,
  output logic rx_valid_o
);
  // Select starts low for a moment so the link logic sees its clearing edge
  initial begin
    sel_n_o = 1'b0;
    sclk_o = 1'b1;
    rx_word_o = 16'h0000;
    rx_ok_o = 1'b0;
    rx_valid_o = 1'b0;
    #1;
    sel_n_o = 1'b1;
  end

  // ----
  // Frame
  // ----
  // Clock stands high outside frames; a spare edge feeds falling-edge capture
  task automatic frame(input bit fall_cap);
    logic ok;
    logic [15:0] w;
    ok = 1'b1;
    w = 16'h0000;
    sel_n_o = 1'b0;
    #(SETUP_NS);
    for (int k = 1; k <= 22; k++) begin
      // Falling-edge capture takes the bit just before the edge that replaces it
      if (fall_cap && k >= 7) w = {w[14:0], sdo_i};
      sclk_o = 1'b0;
      #(HALF_NS);
      sclk_o = 1'b1;
      if (!fall_cap && k >= 6 && k <= 21) w = {w[14:0], sdo_i};
      if (k < 5) ok &= (sdo_oe_n_i === 1'b1);
      else if (k == 5) ok &= (sdo_oe_n_i === 1'b0) && (sdo_i === 1'b0);
      else ok &= (sdo_oe_n_i === 1'b0);
      #(HALF_NS);
    end
    sel_n_o = 1'b1;
    #(HALF_NS);
    ok &= (sdo_oe_n_i === 1'b1);
    rx_word_o = w;
    rx_ok_o = ok;
    rx_valid_o = 1'b1;
    #(HALF_NS);
    rx_valid_o = 1'b0;
  endtask
endmodule

/* dv/test_sar_readout.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`include "sar_params.svh"

module test_sar_readout
  import sar_pkg::*;
;
  localparam int MIN_CYC = 200;
  localparam logic [16:0] TV [8] = '{17'h00000, 17'h00001, 17'h07FFF, 17'h08000,
                                     17'h08001, 17'h0FFFF, 17'h12345, 17'h04321};
  logic core_clk_i, srst_i, ce_i, comp_i, sel_n, sclk, sdo, sdo_oe_n, track, power_up;
  logic rx_ok, rx_valid, below_gnd, first_dac;
  logic [15:0] rx_word;
  logic [16:0] vin;
  sar_code_t dac_code, dac0;
  sar_code_t exp_q[$];
  logic [15:0] fq[$];
  int err_total, tests_run, seed, conv_cnt, pw_cyc;

  sar_readout #(.MIN_FRAME_CYC(MIN_CYC), .FIFO_DEPTH(8)) DUT (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .sel_n_i(sel_n),
    .serial_shift_clock_i(sclk), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .comp_i(comp_i),
    .dac_code_o(dac_code), .track_o(track), .power_up_o(power_up));
  sar_host_model #(.SETUP_NS(600), .HALF_NS(15)) u_host (
    .sel_n_o(sel_n), .sclk_o(sclk), .sdo_i(sdo), .sdo_oe_n_i(sdo_oe_n),
    .rx_word_o(rx_word), .rx_ok_o(rx_ok), .rx_valid_o(rx_valid));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ----
  // Checking
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge rx_valid) begin
    if (exp_q.size() != 0) check(rx_word, exp_q.pop_front());
    check(16'(rx_ok), 16'h0001);
  end

  // Ideal comparator, settled half a cycle after each new trial level
  // Saturation falls out of the search
  always @(negedge core_clk_i) comp_i <= !below_gnd && (vin >= {1'b0, dac_code});

  // Result buffer watched inside the block; a start drops words no frame took
  always @(posedge core_clk_i) begin
    if (srst_i === 1'b1 || (ce_i === 1'b1 && DUT.start === 1'b1)) begin
      fq.delete();
    end else if (ce_i === 1'b1) begin
      if (DUT.push_valid === 1'b1 && DUT.push_ready === 1'b1) fq.push_back(DUT.push_data);
      if (DUT.pop_valid === 1'b1 && DUT.pop_ready === 1'b1) check(DUT.pop_data, fq.pop_front());
    end
  end

  // Edges frozen by the clock enable are not counted
  always @(posedge core_clk_i) begin
    if (power_up === 1'b1 && ce_i === 1'b1) begin
      if (track !== 1'b0) check(16'(track), 16'h0000);
      if (pw_cyc == 0) begin
        conv_cnt++;
        dac0 = dac_code;
        first_dac = 1'b1;
      end else if (first_dac && dac_code !== dac0) begin
        check(dac_code, `SAR_CODE_MID);
        first_dac = 1'b0;
      end
      pw_cyc++;
    end else if (power_up === 1'b0 && pw_cyc != 0) begin
      check(16'(pw_cyc), 16'h0021);
      pw_cyc = 0;
    end
  end

  // ----
  // Stimulus
  // ----
  function automatic sar_code_t code_of(input logic [16:0] v, input logic low);
    if (low) return `SAR_CODE_ZERO;
    if (v[16]) return `SAR_CODE_FULL;
    return v[15:0];
  endfunction

  task automatic do_frame(input logic [16:0] v, input logic low, input bit fall, input sar_code_t e,
                          input bit gap);
    @(posedge core_clk_i);
    vin <= v;
    below_gnd <= low;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    #(2 + ($unsigned($random(seed)) % 7));
    u_host.frame(fall);
    if (gap) repeat (MIN_CYC + 20) @(posedge core_clk_i);
  endtask

  task automatic do_reset(input int n);
    srst_i <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    check(dac_code, `SAR_CODE_ZERO);
    check(16'({track, power_up}), 16'h0002);
  endtask

  // Buffer exercised through the block: word taken, staging released, nothing left over
  task automatic buffer_test();
    do_frame(17'h03C5A, 1'b0, 1'b1, 16'h3C5A, 1'b1);
    #1;
    check(16'(fq.size()), 16'h0000);
    check(16'({DUT.pop_valid, DUT.out_rdy_q}), 16'h0000);
    check(16'(DUT.push_ready), 16'h0001);
    check(DUT.out_word_q, 16'h3C5A);
  endtask

  initial begin
    logic [16:0] v;
    int c0;
    seed = 72;
    err_total = 0;
    tests_run = 0;
    conv_cnt = 0;
    pw_cyc = 0;
    first_dac = 1'b0;
    dac0 = 16'h0000;
    ce_i = 1'b1;
    vin = 17'h00000;
    below_gnd = 1'b0;
    srst_i = 1'b1;
    do_reset(8);
    $display("test reset done");
    for (int i = 0; i < 8; i++) do_frame(TV[i], i == 7, i[0], code_of(TV[i], i == 7), 1'b1);
    $display("test code table done");
    for (int i = 0; i < 6; i++) begin
      v = {1'b0, 16'($random(seed))};
      do_frame(v, 1'b0, i[0], v[15:0], 1'b1);
    end
    $display("test random codes done");
    c0 = conv_cnt;
    do_frame(17'h0A5A5, 1'b0, 1'b0, 16'hA5A5, 1'b0);
    do_frame(17'h05A5A, 1'b0, 1'b0, `SAR_CODE_ZERO, 1'b1);
    check(16'(conv_cnt - c0), 16'h0001);
    do_frame(17'h05A5A, 1'b0, 1'b1, 16'h5A5A, 1'b1);
    $display("test close starts done");
    fork
      do_frame(17'h0C3C3, 1'b0, 1'b0, 16'hC3C3, 1'b1);
      begin
        repeat (10) @(posedge core_clk_i);
        ce_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        ce_i <= 1'b1;
      end
    join
    $display("test clock enable pause done");
    do_reset(2);
    do_frame(17'h0FFFE, 1'b0, 1'b1, 16'hFFFE, 1'b1);
    $display("test second reset done");
    buffer_test();
    $display("test buffer done");
    check(16'(exp_q.size()), 16'h0000);
    stop_test();
  end

  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule

/* verilog/sar_fifo.sv */
// Result FIFO between the bit search and the serial port staging
`timescale 1ns/1ns

module sar_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and control
  input logic clk_i,
  input logic srst_i,
  input logic ce_i,
  input logic flush_i,
  // Write side
  input logic in_valid_i,
  input logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Read side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input logic out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + 1'b1;
  endfunction

  assign in_ready_o = (cnt_q != FULL_CNT);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && flush_i)) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      case ({push, pop})
        2'b10: cnt_q <= cnt_q + 1'b1;
        2'b01: cnt_q <= cnt_q - 1'b1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end

endmodule

/* verilog/sar_params.svh */
// Constants for the serial readout converter control block
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// ----------------------------------------------------------------------
// Data path
// ----------------------------------------------------------------------
`define SAR_RES_BITS 16
`define SAR_FIFO_DEPTH 8
`define SAR_CODE_ZERO 16'h0000
`define SAR_CODE_MID 16'h8000
`define SAR_CODE_FULL 16'hFFFF

// ----------------------------------------------------------------------
// Serial frame, counted in shift clock falling edges after select falls
// ----------------------------------------------------------------------
`define SAR_DRIVE_EDGE 5
`define SAR_LAST_EDGE 21

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SAR_CLK_PERIOD_NS 10
`define SAR_MIN_FRAME_NS 10000
`define SAR_MIN_FRAME_CYC ((`SAR_MIN_FRAME_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)

`endif

/* verilog/sar_pkg.sv */
// Types shared by the serial readout converter control block
package sar_pkg;

  typedef logic [15:0] sar_code_t;

  typedef enum logic [1:0] {
    SAR_IDLE,
    SAR_SAMPLE,
    SAR_TRIAL,
    SAR_DECIDE
  } sar_state_t;

endpackage

/* verilog/sar_readout.sv */
// Converter control: select detect, bit search, result FIFO and serial shift port
`timescale 1ns/1ns
`include "sar_params.svh"

// Summary of operation
// - Select falling edge starts one conversion and the serial result transfer.
// - Output stays off until fifth shift falling edge, then drives zero.
// - Result bits follow, MSB first, one per later shift falling edge.
// - Binary search over 16 weighted steps, MSB decided first.
// - After the search the block returns to acquisition and forms the code.
// - Block powers down automatically at the end of every conversion.
// - A frame carries the result its own select edge started; no latency.
// - Output code is straight binary, midscale 8000, just below 7FFF.
// - Input above reference saturates the code at FFFF.
// - Input below ground saturates the code at 0000.
// - Conversions no faster than 100 kSPS; closer starts are ignored.
// - Serial output is high impedance while select is high.
module sar_readout
  import sar_pkg::*;
#(
  parameter int MIN_FRAME_CYC = `SAR_MIN_FRAME_CYC,
  parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
  // Core clock and control
  input logic core_clk_i,
  input logic srst_i,
  input logic ce_i,
  // Serial port pins
  input logic sel_n_i,
  input logic serial_shift_clock_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  // Analog front end
  input logic comp_i,
  output sar_code_t dac_code_o,
  output logic track_o,
  output logic power_up_o
);

  // ----------------------------------------------------------------------
  // Constants and helpers
  // ----------------------------------------------------------------------
  localparam int GW = $clog2(MIN_FRAME_CYC + 1);
  localparam logic [GW-1:0] GAP_LAST = GW'(MIN_FRAME_CYC - 1);
  localparam logic [4:0] DRIVE_CNT = 5'(`SAR_DRIVE_EDGE - 1);
  localparam logic [4:0] LAST_CNT = 5'(`SAR_LAST_EDGE - 1);
  localparam logic [4:0] SAT_CNT = 5'(`SAR_LAST_EDGE);
  localparam logic [3:0] MSB_IDX = 4'(`SAR_RES_BITS - 1);

  // Weight of one trial bit; straight binary, bit 15 is half scale
  function automatic sar_code_t bit_mask(input logic [3:0] idx);
    return sar_code_t'(16'h0001) << idx;
  endfunction

  // ----------------------------------------------------------------------
  // Core domain signals
  // ----------------------------------------------------------------------
  logic sel_meta_q;
  logic sel_sync_q;
  logic sel_prev_q;
  logic sel_fall;
  logic [GW-1:0] gap_q;
  logic gap_ready;
  logic start;
  sar_state_t state_q;
  sar_state_t state_d;
  logic [3:0] bit_q;
  sar_code_t code_q;
  sar_code_t dac_q;
  logic track_q;
  logic power_q;
  logic all_one_q;
  logic all_zero_q;
  logic push_valid;
  logic push_ready;
  sar_code_t push_data;
  logic pop_valid;
  logic pop_ready;
  sar_code_t pop_data;
  sar_code_t out_word_q;
  logic out_rdy_q;
  logic ack_meta_q;
  logic ack_sync_q;
  logic ack_prev_q;
  logic ack_rise;

  // ----------------------------------------------------------------------
  // Link domain signals, cleared while select is high
  // ----------------------------------------------------------------------
  logic [4:0] cnt_lq;
  logic rdy_meta_lq;
  logic rdy_sync_lq;
  sar_code_t shift_lq;
  logic sdo_lq;
  logic drive_lq;
  logic ack_lq;

  // ----------------------------------------------------------------------
  // Select synchroniser and start detect
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sel_meta_q <= 1'b1;
      sel_sync_q <= 1'b1;
      sel_prev_q <= 1'b1;
    end else if (ce_i) begin
      sel_meta_q <= sel_n_i;
      sel_sync_q <= sel_meta_q;
      sel_prev_q <= sel_sync_q;
    end
  end

  assign sel_fall = sel_prev_q & ~sel_sync_q;
  assign gap_ready = (gap_q == GAP_LAST);
  // A start too soon after the last one is dropped, not queued
  assign start = sel_fall & gap_ready & (state_q == SAR_IDLE);

  // ----------------------------------------------------------------------
  // Throughput guard
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      gap_q <= GAP_LAST;
    end else if (ce_i) begin
      if (start) begin
        gap_q <= '0;
      end else if (!gap_ready) begin
        gap_q <= gap_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Bit search state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      SAR_IDLE: begin
        if (start) begin
          state_d = SAR_SAMPLE;
        end
      end
      SAR_SAMPLE: begin
        state_d = SAR_TRIAL;
      end
      SAR_TRIAL: begin
        state_d = SAR_DECIDE;
      end
      SAR_DECIDE: begin
        if (bit_q != 4'h0) begin
          state_d = SAR_TRIAL;
        end else if (push_ready) begin
          state_d = SAR_IDLE;
        end
      end
      default: begin
        state_d = SAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= SAR_IDLE;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // Switches close for tracking and bias drops whenever the search is idle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      track_q <= 1'b1;
      power_q <= 1'b0;
    end else if (ce_i) begin
      track_q <= (state_d == SAR_IDLE);
      power_q <= (state_d != SAR_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Search data path
  // ----------------------------------------------------------------------
  // Comparator high means the input is at or above the trial level
  assign push_data = code_q | (comp_i ? bit_mask(bit_q) : '0);
  assign push_valid = (state_q == SAR_DECIDE) && (bit_q == 4'h0);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bit_q <= 4'h0;
      code_q <= `SAR_CODE_ZERO;
      dac_q <= `SAR_CODE_ZERO;
    end else if (ce_i) begin
      case (state_q)
        SAR_IDLE: begin
          if (start) begin
            code_q <= `SAR_CODE_ZERO;
          end
        end
        SAR_SAMPLE: begin
          bit_q <= MSB_IDX;
        end
        SAR_TRIAL: begin
          dac_q <= code_q | bit_mask(bit_q);
        end
        SAR_DECIDE: begin
          // Hold the decision while the FIFO refuses the word
          if (bit_q != 4'h0 || push_ready) begin
            code_q <= push_data;
          end
          if (bit_q != 4'h0) begin
            bit_q <= bit_q - 1'b1;
          end
        end
        default: begin
          bit_q <= 4'h0;
        end
      endcase
    end
  end

  // Clamp trackers; a one-sided search pins the code at an end of scale
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      all_one_q <= 1'b1;
      all_zero_q <= 1'b1;
    end else if (ce_i) begin
      if (state_q == SAR_SAMPLE) begin
        all_one_q <= 1'b1;
        all_zero_q <= 1'b1;
      end else if (state_q == SAR_DECIDE && bit_q != 4'h0) begin
        all_one_q <= all_one_q & comp_i;
        all_zero_q <= all_zero_q & ~comp_i;
      end
    end
  end

  assign dac_code_o = dac_q;
  assign track_o = track_q;
  assign power_up_o = power_q;

  // ----------------------------------------------------------------------
  // Result FIFO; a new start flushes words no frame picked up
  // ----------------------------------------------------------------------
  sar_fifo #(
    .WIDTH(`SAR_RES_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .flush_i(start),
    .in_valid_i(push_valid),
    .in_data_i(push_data),
    .in_ready_o(push_ready),
    .out_valid_o(pop_valid),
    .out_data_o(pop_data),
    .out_ready_i(pop_ready)
  );

  // ----------------------------------------------------------------------
  // Staging word handed to the link; held stable until acknowledged
  // ----------------------------------------------------------------------
  assign pop_ready = ~out_rdy_q & ~start;
  assign ack_rise = ack_sync_q & ~ack_prev_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else if (ce_i) begin
      ack_meta_q <= ack_lq;
      ack_sync_q <= ack_meta_q;
      ack_prev_q <= ack_sync_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      out_rdy_q <= 1'b0;
      out_word_q <= `SAR_CODE_ZERO;
    end else if (ce_i) begin
      if (start || ack_rise) begin
        out_rdy_q <= 1'b0;
      end else if (pop_valid && pop_ready) begin
        out_word_q <= pop_data;
        out_rdy_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link side: shift clock domain, select high is its clear
  // ----------------------------------------------------------------------
  always_ff @(negedge serial_shift_clock_i or posedge sel_n_i) begin
    if (sel_n_i) begin
      cnt_lq <= 5'h00;
    end else if (cnt_lq != SAT_CNT) begin
      cnt_lq <= cnt_lq + 1'b1;
    end
  end

  always_ff @(negedge serial_shift_clock_i or posedge sel_n_i) begin
    if (sel_n_i) begin
      rdy_meta_lq <= 1'b0;
      rdy_sync_lq <= 1'b0;
    end else begin
      rdy_meta_lq <= out_rdy_q;
      rdy_sync_lq <= rdy_meta_lq;
    end
  end

  // Bits change only on falling edges, so each is stable a full period
  always_ff @(negedge serial_shift_clock_i or posedge sel_n_i) begin
    if (sel_n_i) begin
      drive_lq <= 1'b0;
      sdo_lq <= 1'b0;
      shift_lq <= `SAR_CODE_ZERO;
      ack_lq <= 1'b0;
    end else if (cnt_lq == DRIVE_CNT) begin
      drive_lq <= 1'b1;
      sdo_lq <= 1'b0;
      if (rdy_sync_lq) begin
        shift_lq <= out_word_q;
        ack_lq <= 1'b1;
      end
    end else if (cnt_lq > DRIVE_CNT && cnt_lq <= LAST_CNT) begin
      sdo_lq <= shift_lq[15];
      shift_lq <= {shift_lq[14:0], 1'b0};
    end else if (cnt_lq > LAST_CNT) begin
      sdo_lq <= 1'b0;
    end
  end

  assign sdo_o = sdo_lq;
  assign sdo_oe_n_o = ~drive_lq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_START_SAMPLE: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && start) |=> (state_q == SAR_SAMPLE) && power_up_o && !track_o)
    else $error("start did not open a conversion");

  AST_RATE_GUARD: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && sel_fall && !gap_ready && state_q == SAR_IDLE) |=> (state_q == SAR_IDLE))
    else $error("start accepted inside the minimum frame period");

  AST_MSB_FIRST_TRIAL: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && state_q == SAR_SAMPLE) ##1 ce_i |=> (dac_code_o == `SAR_CODE_MID))
    else $error("first trial is not half scale");

  AST_TRIAL_LEVEL: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && state_q == SAR_TRIAL) |=> (dac_code_o == ($past(code_q) | bit_mask($past(bit_q)))))
    else $error("trial level does not add the current bit weight");

  AST_DONE_ACQUIRE: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ce_i && push_valid && push_ready) |=> (state_q == SAR_IDLE) && track_o)
    else $error("search end did not return to acquisition");

  AST_POWER_DOWN: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_q == SAR_IDLE) |-> !power_up_o)
    else $error("bias left on while idle");

  AST_SAT_HIGH: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (push_valid && all_one_q && comp_i) |-> (push_data == `SAR_CODE_FULL))
    else $error("overrange did not give all ones");

  AST_SAT_LOW: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (push_valid && all_zero_q && !comp_i) |-> (push_data == `SAR_CODE_ZERO))
    else $error("underrange did not give all zeros");

  AST_HIZ: assert property (@(posedge core_clk_i) disable iff (srst_i)
    sel_n_i |-> sdo_oe_n_o)
    else $error("output driven while select high");

  AST_DRIVE_FIFTH: assert property (@(negedge serial_shift_clock_i) disable iff (sel_n_i)
    (cnt_lq <= DRIVE_CNT) |=> (sdo_oe_n_o == (cnt_lq <= DRIVE_CNT)) && !sdo_o)
    else $error("output enabled at the wrong edge");

  AST_BIT_ORDER: assert property (@(negedge serial_shift_clock_i) disable iff (sel_n_i)
    (cnt_lq > DRIVE_CNT && cnt_lq <= LAST_CNT) |=> (sdo_o == $past(shift_lq[15])) && !sdo_oe_n_o)
    else $error("serial bit out of order");

  AST_LOAD_WORD: assert property (@(negedge serial_shift_clock_i) disable iff (sel_n_i)
    (cnt_lq == DRIVE_CNT && rdy_sync_lq) |=> (shift_lq == out_word_q) && ack_lq)
    else $error("frame did not load the staged result");

endmodule
